// ==== bench/periph_model.sv ====
// Model of the on-chip sources that feed the look-up tables.
// Assumes the bench names one source to carry level; all others carry its inverse.
`timescale 1ns/1ns
`default_nettype none
module periph_model (
	input wire logic [3:0] code,
	input wire logic [1:0] lane,
	input wire logic [2:0] tbl,
	input wire logic level,
	output logic [5:0] event_a,
	output logic [5:0] event_b,
	output logic [17:0] pin_in,
	output logic [2:0] comparator_out,
	output logic [2:0] zero_cross_out,
	output logic [2:0] serial_txd,
	output logic spi_mosi,
	output logic spi_sck,
	output logic [2:0] timer_a0_wave,
	output logic [2:0] timer_a1_wave,
	output logic [2:0] timer_b_out,
	output logic [2:0] timer_d_wave
);
	// ----------------------------------------
	// Source levels
	// ----------------------------------------
	// Unpicked sources are inverted, so a wrong selection reads the wrong level
	always_comb begin
		{event_a, event_b, pin_in, comparator_out, zero_cross_out, serial_txd} = {39{~level}};
		{spi_mosi, spi_sck, timer_a0_wave, timer_a1_wave, timer_b_out, timer_d_wave} = {14{~level}};
		case (code)
			4'h3: event_a[tbl] = level;
			4'h4: event_b[tbl] = level;
			4'h5: pin_in[3 * tbl + lane] = level;
			4'h6: comparator_out[lane] = level;
			4'h7: zero_cross_out[lane] = level;
			4'h8: serial_txd[lane] = level;
			4'h9: begin
				if (lane == 2'h2) spi_sck = level;
				else spi_mosi = level;
			end
			4'hA: timer_a0_wave[lane] = level;
			4'hB: timer_a1_wave[lane] = level;
			4'hC: timer_b_out[lane] = level;
			4'hD: timer_d_wave[lane] = level;
			default: ;
		endcase
	end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench: register access, source selection and truth evaluation.
// Assumes periph_model drives every peripheral source of the block.
`timescale 1ns/1ns
`default_nettype none
`include "lut_defs.svh"
module tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] code = 4'h0;
	logic [1:0] lane = 2'h0;
	logic [2:0] tbl = 3'h0;
	logic level = 1'b0;
	logic [5:0] event_a, event_b, lut_out;
	logic [17:0] pin_in;
	logic [2:0] comparator_out, zero_cross_out, serial_txd;
	logic [2:0] timer_a0_wave, timer_a1_wave, timer_b_out, timer_d_wave;
	logic spi_mosi, spi_sck;
	logic [31:0] rd;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;

	// ----------------------------------------
	// Clock, instances, timeout
	// ----------------------------------------
	always #50 core_clk = ~core_clk;

	periph_model partner (.code, .lane, .tbl, .level, .event_a, .event_b, .pin_in, .comparator_out,
		.zero_cross_out, .serial_txd, .spi_mosi, .spi_sck, .timer_a0_wave, .timer_a1_wave,
		.timer_b_out, .timer_d_wave);

	lut_block #(.NUM_LUT(6)) DUT (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .event_a, .event_b,
		.pin_in, .comparator_out, .zero_cross_out, .serial_txd, .spi_mosi, .spi_sck,
		.timer_a0_wave, .timer_a1_wave, .timer_b_out, .timer_d_wave, .lut_out);

	// Whole run needs some 1500 cycles; the ceiling leaves ample margin
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One bus access, entered just after a rising edge; holds until waitrequest is low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		do @(posedge core_clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask

	function automatic logic [5:0] ix(input logic [5:0] base, input int n);
		return base + 6'(4 * n);
	endfunction

	// Table settings only stick while the unit is globally off
	task automatic cfg(input int n, input logic [7:0] en, selb, selc, truth);
		bus(1'b1, `LUT_GLOBAL_CTRL_IDX, 8'h00);
		bus(1'b1, ix(`LUT_CTRLA_IDX, n), en);
		bus(1'b1, ix(`LUT_SELB_IDX, n), selb);
		bus(1'b1, ix(`LUT_SELC_IDX, n), selc);
		bus(1'b1, ix(`LUT_TRUTH_IDX, n), truth);
		bus(1'b1, `LUT_GLOBAL_CTRL_IDX, 8'h01);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_regs();
		bus(1'b0, ix(`LUT_TRUTH_IDX, 5), 8'h00);
		check(rd, 32'h0);
		bus(1'b1, ix(`LUT_SELC_IDX, 2), 8'hF7);
		bus(1'b0, ix(`LUT_SELC_IDX, 2), 8'h00);
		check(rd, 32'h07);
		bus(1'b1, ix(`LUT_SELB_IDX, 2), 8'h5A);
		avs_byteenable <= 4'h0;
		bus(1'b1, ix(`LUT_SELB_IDX, 2), 8'h11);
		avs_byteenable <= 4'hF;
		bus(1'b0, ix(`LUT_SELB_IDX, 2), 8'h00);
		check(rd, 32'h5A);
		bus(1'b1, 6'h3F, 8'hFF);
		bus(1'b0, 6'h3F, 8'h00);
		check(rd, 32'h0);
	endtask

	// All sources high; a comparator pick reads 1, a mask reads 0
	task automatic test_truth();
		logic [7:0] t;
		for (int i = 0; i < 16; i++) begin
			t = i[3] ? 8'h4B : 8'hB4;
			cfg(0, 8'h01, {i[1] ? 4'h6 : 4'h0, i[0] ? 4'h6 : 4'h0}, i[2] ? 8'h06 : 8'h00, t);
			repeat (5) @(posedge core_clk);
			check(lut_out[0], t[i[2:0]]);
		end
		cfg(0, 8'h00, 8'h66, 8'h06, 8'hFF);
		repeat (5) @(posedge core_clk);
		check(lut_out[0], 1'b0);
		cfg(0, 8'h01, 8'h66, 8'h06, 8'hFF);
		bus(1'b1, ix(`LUT_TRUTH_IDX, 0), 8'h00);
		bus(1'b1, ix(`LUT_CTRLA_IDX, 0), 8'h00);
		repeat (5) @(posedge core_clk);
		check(lut_out[0], 1'b1);
		bus(1'b0, ix(`LUT_TRUTH_IDX, 0), 8'h00);
		check(rd, 32'hFF);
	endtask

	// Source codes 3 to D on every input of table 1, carried low then high
	task automatic test_sources();
		logic [3:0] c;
		for (int k = 0; k < 3; k++) begin
			for (int j = 3; j < 14; j++) begin
				c = 4'(j);
				cfg(1, 8'h01, k == 0 ? {4'h0, c} : k == 1 ? {c, 4'h0} : 8'h00, k == 2 ? {4'h0, c} : 8'h00,
					k == 0 ? 8'hAA : k == 1 ? 8'hCC : 8'hF0);
				code <= c;
				lane <= 2'(k);
				tbl <= 3'h1;
				for (int l = 0; l < 2; l++) begin
					level <= l[0];
					repeat (5) @(posedge core_clk);
					check(lut_out[1], l[0]);
				end
			end
		end
		cfg(1, 8'h01, 8'h00, 8'h00, 8'hFE);
		code <= 4'h0;
		level <= 1'b0;
		repeat (5) @(posedge core_clk);
		check(lut_out[1], 1'b0);
	endtask

	task automatic test_links();
		cfg(2, 8'h01, 8'h00, 8'h00, 8'h01);
		cfg(1, 8'h01, 8'h02, 8'h00, 8'hAA);
		repeat (6) @(posedge core_clk);
		check(lut_out[1], 1'b1);
		code <= 4'h5;
		lane <= 2'h1;
		tbl <= 3'h3;
		level <= 1'b0;
		cfg(3, 8'h01, 8'h51, 8'h00, 8'hFE);
		repeat (5) @(posedge core_clk);
		check(lut_out[3], 1'b0);
		level <= 1'b1;
		repeat (5) @(posedge core_clk);
		level <= 1'b0;
		repeat (5) @(posedge core_clk);
		check(lut_out[3], 1'b1);
		// Tables 0 to 3 are high, 4 and 5 are off
		bus(1'b0, `LUT_OUT_STATUS_IDX, 8'h00);
		check(rd, 32'h0F);
		bus(1'b0, `LUT_GLOBAL_CTRL_IDX, 8'h00);
		check(rd, 32'h01);
		// Own output fed back on input 0, then on input 2; both patterns latch high
		cfg(4, 8'h01, 8'h01, 8'h00, 8'h03);
		repeat (5) @(posedge core_clk);
		check(lut_out[4], 1'b1);
		cfg(4, 8'h01, 8'h00, 8'h01, 8'h11);
		repeat (5) @(posedge core_clk);
		check(lut_out[4], 1'b1);
	endtask

	initial begin
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		test_regs();
		test_truth();
		test_sources();
		test_links();
		finish_test();
	end
endmodule
`default_nettype wire

// ==== hw/input_sync.sv ====
// Two-stage synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// First stage is read only by the second stage
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== hw/lut_block.sv ====
// Six configurable look-up tables with their input selectors, behind an
// Avalon-MM slave with waitrequest. Assumes peripheral sources may be asynchronous.
//
// Contract
// - Each table has an enable at bit 0 of its first control register.
// - Input 1 source comes from bits 7:4 of the second control register.
// - Input 0 source comes from bits 3:0 of the second control register.
// - Input 2 source comes from bits 3:0 of the third control register.
// - Codes 0-4: masked, own feedback, next table, event A, event B.
// - Codes 5-8: pin, comparator, zero-cross, serial transmit k; 9 is MOSI for inputs 0,1.
// - For input 2, code 9 selects the SPI serial clock instead.
// - Codes A-D: type-A timer waveforms, type-B timer k, type-D waveform A/B/C.
// - Output is the pattern bit indexed by the three selected inputs.
`timescale 1ns/1ns
`default_nettype none
`include "lut_defs.svh"
module lut_block #(
	parameter int NUM_LUT = 6
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [NUM_LUT-1:0] event_a,
	input wire logic [NUM_LUT-1:0] event_b,
	input wire logic [3*NUM_LUT-1:0] pin_in,
	input wire logic [2:0] comparator_out,
	input wire logic [2:0] zero_cross_out,
	input wire logic [2:0] serial_txd,
	input wire logic spi_mosi,
	input wire logic spi_sck,
	input wire logic [2:0] timer_a0_wave,
	input wire logic [2:0] timer_a1_wave,
	input wire logic [2:0] timer_b_out,
	input wire logic [2:0] timer_d_wave,
	output logic [NUM_LUT-1:0] lut_out
);
	import lut_pkg::*;

	// ----------------------------------------
	// Source synchronisation
	// ----------------------------------------
	localparam int SYNC_W = 23 + 5 * NUM_LUT;

	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_w;
	logic mosi_s;
	logic sck_s;
	logic [2:0] cmp_s;
	logic [2:0] zcd_s;
	logic [2:0] txd_s;
	logic [2:0] ta0_s;
	logic [2:0] ta1_s;
	logic [2:0] tb_s;
	logic [2:0] td_s;
	logic [3*NUM_LUT-1:0] pin_s;
	logic [NUM_LUT-1:0] eva_s;
	logic [NUM_LUT-1:0] evb_s;

	// All peripheral levels are treated as foreign; costs two cycles of latency
	assign sync_in = {event_b, event_a, pin_in, timer_d_wave, timer_b_out, timer_a1_wave,
		timer_a0_wave, serial_txd, zero_cross_out, comparator_out, spi_sck, spi_mosi};

	input_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.async_in(sync_in),
		.sync_out(sync_w)
	);

	// Unpack the synchronised bus
	assign mosi_s = sync_w[0];
	assign sck_s = sync_w[1];
	assign cmp_s = sync_w[4:2];
	assign zcd_s = sync_w[7:5];
	assign txd_s = sync_w[10:8];
	assign ta0_s = sync_w[13:11];
	assign ta1_s = sync_w[16:14];
	assign tb_s = sync_w[19:17];
	assign td_s = sync_w[22:20];
	assign pin_s = sync_w[23 +: 3*NUM_LUT];
	assign eva_s = sync_w[23+3*NUM_LUT +: NUM_LUT];
	assign evb_s = sync_w[23+4*NUM_LUT +: NUM_LUT];

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	logic req_w;
	logic accept_w;
	logic wr_w;
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	assign req_w = avs_read | avs_write;
	// Access completes in the cycle where waitrequest is low
	assign accept_w = req_w & ~wait_q;
	assign wr_w = avs_write & ~wait_q & avs_byteenable[0];
	// One wait cycle per access, then waitrequest drops for exactly one cycle
	assign wait_d = ~(req_w & wait_q);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= wait_d;
		end
	end

	assign avs_waitrequest = wait_q;

	// ----------------------------------------
	// Global control and status
	// ----------------------------------------
	logic glob_en_q;
	logic hit_glob_w;
	logic hit_stat_w;
	logic cfg_open_w;

	assign hit_glob_w = avs_address == `LUT_GLOBAL_CTRL_IDX;
	assign hit_stat_w = avs_address == `LUT_OUT_STATUS_IDX;
	// Configuration may change only with the unit stopped
	assign cfg_open_w = ~glob_en_q;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			glob_en_q <= 1'b0;
		end else if (wr_w && hit_glob_w) begin
			glob_en_q <= avs_writedata[`LUT_GLOBAL_EN_BIT];
		end
	end

	// ----------------------------------------
	// Per-table registers and cells
	// ----------------------------------------
	reg_byte_t ctrla_q [NUM_LUT];
	reg_byte_t selb_q [NUM_LUT];
	reg_byte_t selc_q [NUM_LUT];
	reg_byte_t truth_q [NUM_LUT];
	logic [31:0] rd_term [NUM_LUT];
	logic [NUM_LUT-1:0] any_hit_w;

	genvar n;
	genvar k;
	generate
		for (n = 0; n < NUM_LUT; n++) begin : g_lut
			localparam logic [5:0] OFS = 6'(4 * n);
			logic hit_a;
			logic hit_b;
			logic hit_c;
			logic hit_t;
			logic prot_wr;
			src_vec_t src [3];

			assign hit_a = avs_address == (`LUT_CTRLA_IDX + OFS);
			assign hit_b = avs_address == (`LUT_SELB_IDX + OFS);
			assign hit_c = avs_address == (`LUT_SELC_IDX + OFS);
			assign hit_t = avs_address == (`LUT_TRUTH_IDX + OFS);
			assign any_hit_w[n] = hit_a | hit_b | hit_c | hit_t;
			// Protected writes are dropped silently while running
			assign prot_wr = wr_w & cfg_open_w;

			// Control, selector and pattern registers
			always_ff @(posedge core_clk) begin
				if (!rst_b) begin
					ctrla_q[n] <= `LUT_REG_RESET;
					selb_q[n] <= `LUT_REG_RESET;
					selc_q[n] <= `LUT_REG_RESET;
					truth_q[n] <= `LUT_REG_RESET;
				end else begin
					if (prot_wr && hit_a) ctrla_q[n] <= avs_writedata[7:0];
					if (prot_wr && hit_b) selb_q[n] <= avs_writedata[7:0];
					if (prot_wr && hit_c) selc_q[n] <= {4'h0, avs_writedata[3:0]};
					if (prot_wr && hit_t) truth_q[n] <= avs_writedata[7:0];
				end
			end

			// Read-back term for this table
			assign rd_term[n] = hit_a ? {24'h000000, ctrla_q[n]} :
				hit_b ? {24'h000000, selb_q[n]} :
				hit_c ? {24'h000000, selc_q[n]} :
				hit_t ? {24'h000000, truth_q[n]} : 32'h00000000;

			// Source vector for each input; index is the selector code
			for (k = 0; k < 3; k++) begin : g_in
				assign src[k][SRC_MASK] = 1'b0;
				assign src[k][SRC_FEEDBACK] = lut_out[n];
				assign src[k][SRC_LINK] = lut_out[(n + 1) % NUM_LUT];
				assign src[k][SRC_EVENT_A] = eva_s[n];
				assign src[k][SRC_EVENT_B] = evb_s[n];
				assign src[k][SRC_PIN] = pin_s[3*n + k];
				assign src[k][SRC_COMPARATOR] = cmp_s[k];
				assign src[k][SRC_ZERO_CROSS] = zcd_s[k];
				// Valid only with the serial port in async or sync host mode
				assign src[k][SRC_SERIAL_TXD] = txd_s[k];
				// Valid only with the SPI in host mode
				assign src[k][SRC_SPI] = (k == 2) ? sck_s : mosi_s;
				assign src[k][SRC_TIMER_A0] = ta0_s[k];
				assign src[k][SRC_TIMER_A1] = ta1_s[k];
				assign src[k][SRC_TIMER_B] = tb_s[k];
				assign src[k][SRC_TIMER_D] = td_s[k];
				assign src[k][15:14] = 2'b00; // Reserved codes read as masked
			end

			lut_cell u_cell (
				.core_clk(core_clk),
				.rst_b(rst_b),
				.enable(glob_en_q & ctrla_q[n][`LUT_ENABLE_BIT]),
				.sel0(src_code_e'(selb_q[n][`LUT_IN0_SEL_MSB:`LUT_IN0_SEL_LSB])),
				.sel1(src_code_e'(selb_q[n][`LUT_IN1_SEL_MSB:`LUT_IN1_SEL_LSB])),
				.sel2(src_code_e'(selc_q[n][`LUT_IN2_SEL_MSB:`LUT_IN2_SEL_LSB])),
				.truth(truth_q[n]),
				.src0(src[0]),
				.src1(src[1]),
				.src2(src[2]),
				.out_q(lut_out[n])
			);
		end
	endgenerate

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Unmapped addresses read as zero; reads have no side effects
	always_comb begin
		rdata_d = 32'h00000000;
		if (hit_glob_w) rdata_d = {31'h00000000, glob_en_q};
		if (hit_stat_w) rdata_d = {{(32-NUM_LUT){1'b0}}, lut_out};
		for (int i = 0; i < NUM_LUT; i++) begin
			rdata_d = rdata_d | rd_term[i];
		end
	end

	// Captured during the wait cycle so it stands while waitrequest is low
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rdata_q <= 32'h00000000;
		end else if (avs_read && wait_q) begin
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata = rdata_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_wait_one: assert property (req_w && wait_q |=> !wait_q)
		else $error("waitrequest did not drop after one wait cycle");
	a_wait_idle: assert property (!wait_q |=> wait_q)
		else $error("waitrequest low for more than one cycle");
	a_protect_truth: assert property (glob_en_q && avs_write |=> $stable(truth_q[0]) && $stable(selb_q[0]))
		else $error("protected register changed while enabled");
	a_selb_write: assert property (wr_w && cfg_open_w && avs_address == `LUT_SELB_IDX
		|=> selb_q[0] == $past(avs_writedata[7:0]))
		else $error("selector write lost while disabled");
	a_selc_upper: assert property (selc_q[0][7:4] == 4'h0)
		else $error("upper selector bits not zero");
	a_enable_write: assert property (wr_w && cfg_open_w && avs_address == `LUT_CTRLA_IDX
		|=> ctrla_q[0][`LUT_ENABLE_BIT] == $past(avs_writedata[0]))
		else $error("enable bit write lost");
	a_status_read: assert property (avs_read && wait_q && hit_stat_w
		|=> avs_readdata == {{(32-NUM_LUT){1'b0}}, $past(lut_out)})
		else $error("status read does not show table outputs");
	a_unmapped_zero: assert property (avs_read && wait_q && !hit_glob_w && !hit_stat_w && !(|any_hit_w)
		|=> avs_readdata == 32'h00000000)
		else $error("unmapped read not zero");

	// ----------------------------------------
	// Register and datapath checks
	// ----------------------------------------
	// Each write accepted while the unit is stopped lands in its register on the acknowledge edge
	a_truth_write: assert property (wr_w && cfg_open_w && avs_address == `LUT_TRUTH_IDX
		|=> truth_q[0] == $past(avs_writedata[7:0]))
		else $error("truth pattern write lost while disabled");
	a_selc_write: assert property (wr_w && cfg_open_w && avs_address == `LUT_SELC_IDX
		|=> selc_q[0][3:0] == $past(avs_writedata[3:0]))
		else $error("input 2 selector write lost while disabled");
	// The global enable itself is never protected, else the unit could never be stopped
	a_global_write: assert property (wr_w && hit_glob_w
		|=> glob_en_q == $past(avs_writedata[`LUT_GLOBAL_EN_BIT]))
		else $error("global enable write lost");
	// Control A and the input 2 selector are guarded like the pattern
	a_protect_ctrl: assert property (glob_en_q && avs_write
		|=> $stable(ctrla_q[0]) && $stable(selc_q[0]))
		else $error("protected control register changed while enabled");
	// A write with byte lane 0 off must leave every register alone
	a_write_lane: assert property (avs_write && !wait_q && !avs_byteenable[0]
		|=> $stable(glob_en_q) && $stable(selb_q[2]) && $stable(truth_q[2]))
		else $error("write with byte lane 0 off changed a register");
	// A stopped unit drives all outputs low on the next edge
	a_out_gated: assert property (!glob_en_q |=> lut_out == '0)
		else $error("table output high while unit stopped");
	// A table with its own enable low stays low even with the unit running
	a_table_off: assert property (!ctrla_q[0][`LUT_ENABLE_BIT] |=> !lut_out[0])
		else $error("table 0 output high while its enable is low");
	// Read data move only when a read is taken, so software sees a steady word
	a_read_hold: assert property (!(avs_read && wait_q) |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	a_read_upper: assert property (avs_read && wait_q |=> avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	// Table 1 fed from table 2 sees the registered link one cycle late
	a_link_follow: assert property (glob_en_q && ctrla_q[1][`LUT_ENABLE_BIT]
		&& selb_q[1] == 8'h02 && selc_q[1][3:0] == 4'h0
		|=> lut_out[1] == $past(truth_q[1][{2'b00, lut_out[2]}]))
		else $error("link input does not follow the next table");
	// Code 9 on input 2 is the SPI clock, on input 0 the data line
	a_spi_clock: assert property (glob_en_q && ctrla_q[1][`LUT_ENABLE_BIT]
		&& selb_q[1] == 8'h00 && selc_q[1][3:0] == 4'h9
		|=> lut_out[1] == $past(truth_q[1][{sck_s, 2'b00}]))
		else $error("input 2 code 9 does not take the SPI clock");
	a_spi_data: assert property (glob_en_q && ctrla_q[1][`LUT_ENABLE_BIT]
		&& selb_q[1] == 8'h09 && selc_q[1][3:0] == 4'h0
		|=> lut_out[1] == $past(truth_q[1][{2'b00, mosi_s}]))
		else $error("input 0 code 9 does not take the SPI data line");

	c_blocked_write: cover property (glob_en_q && wr_w && (|any_hit_w));
	c_status_read: cover property (avs_read && !wait_q && hit_stat_w);
	c_global_start: cover property ($rose(glob_en_q));
	// Two linked tables both high
	c_link_chain: cover property (glob_en_q && lut_out[2] && lut_out[1]);
endmodule
`default_nettype wire

// ==== hw/lut_cell.sv ====
// One three-input look-up table: input selection and truth-pattern evaluation.
// Assumes source vectors are already synchronised to core_clk.
`timescale 1ns/1ns
`default_nettype none
module lut_cell (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire lut_pkg::src_code_e sel0,
	input wire lut_pkg::src_code_e sel1,
	input wire lut_pkg::src_code_e sel2,
	input wire lut_pkg::reg_byte_t truth,
	input wire lut_pkg::src_vec_t src0,
	input wire lut_pkg::src_vec_t src1,
	input wire lut_pkg::src_vec_t src2,
	output logic out_q
);
	import lut_pkg::*;

	logic [2:0] table_input_vector;
	logic out_d;

	// Input 0 is the low index bit, input 2 the high one
	assign table_input_vector = {src2[sel2], src1[sel1], src0[sel0]};
	assign out_d = enable & truth[table_input_vector];

	// Registered output also serves as feedback and link source without a loop
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			out_q <= 1'b0;
		end else begin
			out_q <= out_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_disabled_low: assert property (@(posedge core_clk) disable iff (!rst_b) !enable |=> !out_q)
		else $error("disabled table output not low");
	a_masked_index: assert property (@(posedge core_clk) disable iff (!rst_b)
		enable && sel0 == SRC_MASK && sel1 == SRC_MASK && sel2 == SRC_MASK |=> out_q == $past(truth[0]))
		else $error("masked inputs do not select pattern bit 0");
	a_feedback_low: assert property (@(posedge core_clk) disable iff (!rst_b)
		enable && sel0 == SRC_FEEDBACK && sel1 == SRC_MASK && sel2 == SRC_MASK
		|=> out_q == $past(truth[{2'b00, out_q}]))
		else $error("feedback on input 0 picks wrong pattern bit");
	a_index_order: assert property (@(posedge core_clk) disable iff (!rst_b)
		enable && sel0 == SRC_MASK && sel1 == SRC_MASK && sel2 == SRC_FEEDBACK
		|=> out_q == $past(truth[{out_q, 2'b00}]))
		else $error("input 2 is not the high index bit");
	c_output_rises: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(out_q));
endmodule
`default_nettype wire

// ==== include/lut_defs.svh ====
// Register indices, field positions and reset values of the look-up table block.
// Assumes word-indexed register access; byte address is four times the index.
`ifndef LUT_DEFS_SVH
`define LUT_DEFS_SVH

// Register indices (word index on the bus)
`define LUT_GLOBAL_CTRL_IDX 6'h00
`define LUT_OUT_STATUS_IDX 6'h04
`define LUT_CTRLA_IDX 6'h08
`define LUT_SELB_IDX 6'h09
`define LUT_SELC_IDX 6'h0A
`define LUT_TRUTH_IDX 6'h0B
`define LUT_STRIDE 6'h04

// Field positions
`define LUT_ENABLE_BIT 0
`define LUT_GLOBAL_EN_BIT 0
`define LUT_IN1_SEL_MSB 7
`define LUT_IN1_SEL_LSB 4
`define LUT_IN0_SEL_MSB 3
`define LUT_IN0_SEL_LSB 0
`define LUT_IN2_SEL_MSB 3
`define LUT_IN2_SEL_LSB 0

// Reset values
`define LUT_REG_RESET 8'h00

`endif

// ==== include/lut_pkg.sv ====
// Types shared by the look-up table block.
// Assumes nothing of its surroundings.
package lut_pkg;

	// Input source codes of each table input selector
	typedef enum logic [3:0] {
		SRC_MASK = 4'h0,
		SRC_FEEDBACK = 4'h1,
		SRC_LINK = 4'h2,
		SRC_EVENT_A = 4'h3,
		SRC_EVENT_B = 4'h4,
		SRC_PIN = 4'h5,
		SRC_COMPARATOR = 4'h6,
		SRC_ZERO_CROSS = 4'h7,
		SRC_SERIAL_TXD = 4'h8,
		SRC_SPI = 4'h9,
		SRC_TIMER_A0 = 4'hA,
		SRC_TIMER_A1 = 4'hB,
		SRC_TIMER_B = 4'hC,
		SRC_TIMER_D = 4'hD
	} src_code_e;

	typedef logic [7:0] reg_byte_t;
	typedef logic [15:0] src_vec_t;

endpackage
